/* hdl/mvkd_consts.vh */
`ifndef MVKD_CONSTS_VH
`define MVKD_CONSTS_VH
`define MVKD_OP_VERIFY 8'h28
`define MVKD_OP_KEYUPD 8'h1C
`define MVKD_OP_REV 8'h30
`define MVKD_VM_FIRST 1
`define MVKD_VM_SECOND 0
`define MVKD_VM_NONCE 2
`define MVKD_VM_OTP 5
`define MVKD_VM_MBZ 8'hD8
`define MVKD_KU_NONCE 2
`define MVKD_KU_MBZ 8'hFB
`define MVKD_POL_MAC 15
`define MVKD_POL_ENABLE 13
`define MVKD_POL_CREATE 12
`define MVKD_POL_PARENT_HI 11
`define MVKD_POL_PARENT_LO 8
`define MVKD_POL_LIMITED 5
`define MVKD_SLOT_HI 3
`define MVKD_VM_DATA_LEN 7'h4D
`define MVKD_KU_MAC_LEN 7'h20
`define MVKD_RESP_BASE 32
`define MVKD_EXTRA_BASE 64
`define MVKD_MSG_LEN_VERIFY 7'h58
`define MVKD_MSG_LEN_MAC 7'h27
`define MVKD_MSG_LEN_DERIVE 7'h60
`define MVKD_RES_OK 8'h00
`define MVKD_RES_MISMATCH 8'h01
`define MVKD_ERR_PARSE 8'h03
`define MVKD_ERR_EXEC 8'h0F
`define MVKD_BUDGET_RST 8'hFF
`define MVKD_BUDGET_FULL 8'hFF
`define MVKD_BUDGET_EMPTY 8'h00
`define MVKD_RCNT_RST 8'h00
`define MVKD_RCNT_STEP 8'h01
`define MVKD_LEN_ONE 3'h1
`define MVKD_LEN_FOUR 3'h4
`endif

/* hdl/mvkd_cmd.v */
`timescale 1ns/1ps
`include "mvkd_consts.vh"
module mvkd_cmd #(
  parameter [31:0] REV_WORD = 32'h0000_0001 // arbitrary value
) (
  input wire core_clk,
  input wire reset_n,
  input wire cmd_valid,
  input wire [7:0] cmd_opcode,
  input wire [7:0] cmd_param1,
  input wire [15:0] cmd_param2,
  input wire din_valid,
  input wire [7:0] din_byte,
  input wire [255:0] temp_digest,
  input wire temp_valid,
  input wire nonce_origin_flag,
  input wire [71:0] serial_num,
  input wire [63:0] otp_low,
  input wire [15:0] pol_rd_data,
  input wire [255:0] key_rd_data,
  input wire sha_done,
  input wire [255:0] sha_digest,
  input wire [2:0] ctr_sel,
  output reg busy_ff,
  output reg rsp_valid_ff,
  output reg [2:0] rsp_len_ff,
  output reg [31:0] rsp_data_ff,
  output reg [3:0] pol_rd_slot_ff,
  output reg [3:0] key_rd_slot_ff,
  output reg sha_start_ff,
  output reg [767:0] sha_msg_ff,
  output reg [6:0] sha_len_ff,
  output reg key_wr_en_ff,
  output reg [3:0] key_wr_slot_ff,
  output reg [255:0] key_wr_data_ff,
  output reg [7:0] ctr_budget_ff,
  output reg [7:0] ctr_rewrite_ff
);

  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_POL = 8'h02;
  localparam [7:0] ST_PPOL = 8'h04;
  localparam [7:0] ST_DATA = 8'h08;
  localparam [7:0] ST_CHECK = 8'h10;
  localparam [7:0] ST_KEY = 8'h20;
  localparam [7:0] ST_HASH = 8'h40;
  localparam [7:0] ST_DONE = 8'h80;
  localparam DATA_BYTES = 77;

  reg [7:0] state_ff;
  reg [7:0] op_ff;
  reg [7:0] p1_ff;
  reg [15:0] p2_ff;
  reg [15:0] dpol_ff;
  reg [15:0] ppol_ff;
  reg [6:0] cnt_ff;
  reg [6:0] need_ff;
  reg mac_phase_ff;
  reg [7:0] data_mem_ff [0:DATA_BYTES-1];
  reg [7:0] budget_ff [0:7];
  reg [7:0] rcnt_ff [0:7];
  integer i;

  wire [255:0] chal_w;
  wire [255:0] resp_w;
  wire [103:0] extra_w;
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_pack
      assign chal_w[255-8*g -: 8] = data_mem_ff[g];
      assign resp_w[255-8*g -: 8] = data_mem_ff[`MVKD_RESP_BASE+g];
    end
    for (g = 0; g < 13; g = g + 1) begin : g_extra
      assign extra_w[103-8*g -: 8] = data_mem_ff[`MVKD_EXTRA_BASE+g];
    end
  endgenerate

  // first byte of every field sits in the top bits
  wire [7:0] sn8_w = serial_num[7:0];
  wire [15:0] sn01_w = serial_num[71:56];
  wire [3:0] dest_w = p2_ff[3:0];
  wire [3:0] parent_w = dpol_ff[`MVKD_POL_PARENT_HI:`MVKD_POL_PARENT_LO];
  wire create_w = dpol_ff[`MVKD_POL_CREATE];
  wire need_mac_w = dpol_ff[`MVKD_POL_MAC];
  wire [3:0] src_w = create_w ? parent_w : dest_w;
  // slots 8-15 keep no budget, so they never block
  wire parent_empty_w = !parent_w[`MVKD_SLOT_HI] && (budget_ff[parent_w[2:0]] == `MVKD_BUDGET_EMPTY);
  wire vm_uses_temp_w = p1_ff[`MVKD_VM_FIRST] | p1_ff[`MVKD_VM_SECOND];

  wire [255:0] vm_first_w = p1_ff[`MVKD_VM_FIRST] ? temp_digest : key_rd_data;
  wire [255:0] vm_second_w = p1_ff[`MVKD_VM_SECOND] ? temp_digest : chal_w;
  wire [63:0] vm_otp_w = p1_ff[`MVKD_VM_OTP] ? otp_low : 64'h0;
  wire [767:0] vm_msg_w = {vm_first_w, vm_second_w, extra_w[103:72], vm_otp_w, extra_w[71:48],
                           sn8_w, extra_w[47:16], sn01_w, extra_w[15:0], 64'h0};
  wire [767:0] mac_msg_w = {key_rd_data, op_ff, p1_ff, p2_ff, sn8_w, sn01_w, 456'h0};
  wire [767:0] drv_msg_w = {key_rd_data, op_ff, p1_ff, p2_ff, sn8_w, sn01_w, 200'h0, temp_digest};

  task finish;
    input [7:0] code;
    begin
      rsp_valid_ff <= 1'b1;
      rsp_len_ff <= `MVKD_LEN_ONE;
      rsp_data_ff <= {24'h0, code};
      state_ff <= ST_DONE;
    end
  endtask

  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      op_ff <= 8'h00;
      p1_ff <= 8'h00;
      p2_ff <= 16'h0000;
      dpol_ff <= 16'h0000;
      ppol_ff <= 16'h0000;
      cnt_ff <= 7'h00;
      need_ff <= 7'h00;
      mac_phase_ff <= 1'b0;
      busy_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_len_ff <= 3'h0;
      rsp_data_ff <= 32'h0;
      pol_rd_slot_ff <= 4'h0;
      key_rd_slot_ff <= 4'h0;
      sha_start_ff <= 1'b0;
      sha_msg_ff <= 768'h0;
      sha_len_ff <= 7'h00;
      key_wr_en_ff <= 1'b0;
      key_wr_slot_ff <= 4'h0;
      key_wr_data_ff <= 256'h0;
      ctr_budget_ff <= `MVKD_BUDGET_RST;
      ctr_rewrite_ff <= `MVKD_RCNT_RST;
      for (i = 0; i < 8; i = i + 1) begin
        budget_ff[i] <= `MVKD_BUDGET_RST;
        rcnt_ff[i] <= `MVKD_RCNT_RST;
      end
    end else begin
      rsp_valid_ff <= 1'b0;
      sha_start_ff <= 1'b0;
      key_wr_en_ff <= 1'b0;
      ctr_budget_ff <= budget_ff[ctr_sel];
      ctr_rewrite_ff <= rcnt_ff[ctr_sel];
      case (state_ff)
        ST_IDLE: begin
          busy_ff <= 1'b0;
          if (cmd_valid) begin
            busy_ff <= 1'b1;
            op_ff <= cmd_opcode;
            p1_ff <= cmd_param1;
            p2_ff <= cmd_param2;
            cnt_ff <= 7'h00;
            mac_phase_ff <= 1'b0;
            pol_rd_slot_ff <= cmd_param2[3:0];
            if (cmd_opcode == `MVKD_OP_REV) begin
              if (cmd_param1 != 8'h00 || cmd_param2 != 16'h0000) begin
                finish(`MVKD_ERR_PARSE);
              end else begin
                rsp_valid_ff <= 1'b1;
                rsp_len_ff <= `MVKD_LEN_FOUR;
                rsp_data_ff <= REV_WORD;
                state_ff <= ST_DONE;
              end
            end else if (cmd_opcode == `MVKD_OP_VERIFY || cmd_opcode == `MVKD_OP_KEYUPD) begin
              state_ff <= ST_POL;
            end else begin
              finish(`MVKD_ERR_PARSE);
            end
          end
        end
        ST_POL: begin
          dpol_ff <= pol_rd_data;
          pol_rd_slot_ff <= pol_rd_data[`MVKD_POL_PARENT_HI:`MVKD_POL_PARENT_LO];
          state_ff <= ST_PPOL;
        end
        ST_PPOL: begin
          ppol_ff <= pol_rd_data;
          if (op_ff == `MVKD_OP_VERIFY) begin
            need_ff <= `MVKD_VM_DATA_LEN;
            state_ff <= ST_DATA;
          end else if (need_mac_w) begin
            need_ff <= `MVKD_KU_MAC_LEN;
            state_ff <= ST_DATA;
          end else begin
            need_ff <= 7'h00;
            state_ff <= ST_CHECK;
          end
        end
        ST_DATA: begin
          // bytes beyond the expected count are never stored
          if (din_valid) begin
            data_mem_ff[cnt_ff] <= din_byte;
            cnt_ff <= cnt_ff + 7'h01;
            if (cnt_ff + 7'h01 == need_ff) begin
              state_ff <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (op_ff == `MVKD_OP_VERIFY) begin
            key_rd_slot_ff <= dest_w;
            if ((p1_ff & `MVKD_VM_MBZ) != 8'h00) begin
              finish(`MVKD_ERR_PARSE);
            end else if (vm_uses_temp_w && (!temp_valid || p1_ff[`MVKD_VM_NONCE] != nonce_origin_flag)) begin
              finish(`MVKD_ERR_EXEC);
            end else begin
              state_ff <= ST_KEY;
            end
          end else if (!dpol_ff[`MVKD_POL_ENABLE]) begin
            finish(`MVKD_ERR_EXEC);
          end else if ((p1_ff & `MVKD_KU_MBZ) != 8'h00 || !temp_valid ||
                       p1_ff[`MVKD_KU_NONCE] != nonce_origin_flag) begin
            finish(`MVKD_ERR_PARSE);
          end else if ((create_w || need_mac_w) && ppol_ff[`MVKD_POL_LIMITED] && parent_empty_w) begin
            finish(`MVKD_ERR_EXEC);
          end else begin
            mac_phase_ff <= need_mac_w;
            key_rd_slot_ff <= need_mac_w ? parent_w : src_w;
            state_ff <= ST_KEY;
          end
        end
        ST_KEY: begin
          sha_start_ff <= 1'b1;
          if (op_ff == `MVKD_OP_VERIFY) begin
            sha_msg_ff <= vm_msg_w;
            sha_len_ff <= `MVKD_MSG_LEN_VERIFY;
          end else if (mac_phase_ff) begin
            sha_msg_ff <= mac_msg_w;
            sha_len_ff <= `MVKD_MSG_LEN_MAC;
          end else begin
            sha_msg_ff <= drv_msg_w;
            sha_len_ff <= `MVKD_MSG_LEN_DERIVE;
          end
          state_ff <= ST_HASH;
        end
        ST_HASH: begin
          if (sha_done) begin
            if (op_ff == `MVKD_OP_VERIFY) begin
              finish((sha_digest == resp_w) ? `MVKD_RES_OK : `MVKD_RES_MISMATCH);
            end else if (mac_phase_ff) begin
              if (sha_digest != chal_w) begin
                finish(`MVKD_ERR_EXEC);
              end else begin
                mac_phase_ff <= 1'b0;
                key_rd_slot_ff <= src_w;
                state_ff <= ST_KEY;
              end
            end else begin
              key_wr_en_ff <= 1'b1;
              key_wr_slot_ff <= dest_w;
              key_wr_data_ff <= sha_digest;
              if (!dest_w[`MVKD_SLOT_HI]) begin
                budget_ff[dest_w[2:0]] <= `MVKD_BUDGET_FULL;
                rcnt_ff[dest_w[2:0]] <= rcnt_ff[dest_w[2:0]] + `MVKD_RCNT_STEP;
              end
              finish(`MVKD_RES_OK);
            end
          end
        end
        ST_DONE: begin
          // one idle cycle between answer and next command
          busy_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // mvkd_cmd

/* sim/mvkd_chk.sv */
`timescale 1ns/1ps
`include "mvkd_consts.vh"
module mvkd_chk (
  input wire core_clk,
  input wire reset_n,
  input wire cmd_valid,
  input wire [7:0] cmd_opcode,
  input wire [7:0] cmd_param1,
  input wire [15:0] cmd_param2,
  input wire sha_done,
  input wire busy_ff,
  input wire rsp_valid_ff,
  input wire [2:0] rsp_len_ff,
  input wire [31:0] rsp_data_ff,
  input wire [3:0] pol_rd_slot_ff,
  input wire sha_start_ff,
  input wire [6:0] sha_len_ff,
  input wire key_wr_en_ff
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  wire take = cmd_valid && !busy_ff;
  wire rev = take && cmd_opcode == `MVKD_OP_REV;
  sequence s_tail;
    busy_ff ##1 !busy_ff;
  endsequence
  a_rev_ok: assert property (rev && cmd_param1 == 8'h00 && cmd_param2 == 16'h0000
    |=> rsp_valid_ff && rsp_len_ff == 3'h4) else $error("revision answer wrong");
  a_rev_bad: assert property (rev && cmd_param1 != 8'h00
    |=> rsp_valid_ff && rsp_data_ff[7:0] == `MVKD_ERR_PARSE) else $error("bad revision not refused");
  a_verify_slot: assert property (take && cmd_opcode == `MVKD_OP_VERIFY
    |=> {12'h000, pol_rd_slot_ff} == ($past(cmd_param2) & 16'h000F)) else $error("verify slot wrong");
  a_resp_tail: assert property (rsp_valid_ff |-> s_tail) else $error("busy tail wrong");
  a_resp_pulse: assert property (rsp_valid_ff |=> !rsp_valid_ff) else $error("answer too long");
  a_write_ok: assert property (key_wr_en_ff
    |-> rsp_valid_ff && rsp_data_ff[7:0] == `MVKD_RES_OK) else $error("write without success");
  a_write_sha: assert property (key_wr_en_ff |-> $past(sha_done)) else $error("write not after hash");
  a_sha_len: assert property (sha_start_ff
    |-> sha_len_ff inside {7'h58, 7'h27, 7'h60}) else $error("hash length wrong");
endmodule // mvkd_chk

/* sim/mvkd_store.sv */
`timescale 1ns/1ps
module mvkd_store (
  input wire core_clk,
  input wire [3:0] pol_slot,
  input wire [3:0] key_slot,
  input wire sha_start,
  input wire [6:0] sha_len,
  output reg [15:0] pol_data,
  output wire [255:0] key_data,
  output reg sha_done,
  output reg [255:0] sha_digest
);
  reg [1:0] cnt_ff = 2'h0;
  reg [6:0] len_ff = 7'h00;
  // key bytes carry their slot so a wrong index shows
  assign key_data = {32{4'hA, key_slot}};
  always @* begin
    case (pol_slot)
      4'h2: pol_data = 16'h2000;
      4'h4: pol_data = 16'hB200;
      default: pol_data = 16'h0000;
    endcase
  end
  // digest only valid with done; toggles otherwise so stale use fails
  always @(posedge core_clk) begin
    sha_done <= cnt_ff == 2'h1;
    cnt_ff <= sha_start ? 2'h3 : cnt_ff - {1'b0, cnt_ff != 2'h0};
    len_ff <= sha_start ? sha_len : len_ff;
    sha_digest <= cnt_ff == 2'h1 ? {32{1'b0, len_ff}} : ~sha_digest;
  end
endmodule // mvkd_store

/* sim/tb.sv */
`timescale 1ns/1ps
`include "mvkd_consts.vh"
module tb;
  localparam [255:0] tmp = {32{8'h7E}};
  reg core_clk = 0;
  reg reset_n = 0;
  reg cv = 0;
  reg dv = 0;
  reg [7:0] op = 0;
  reg [7:0] p1 = 0;
  reg [7:0] db = 0;
  reg [15:0] p2 = 0;
  reg [2:0] sel = 3'h2;
  reg tv = 1;
  reg nf = 0;
  reg [3:0] wsl;
  reg [255:0] wk;
  reg [767:0] m;
  reg [31:0] v;
  wire busy, rv, st, sd, we;
  wire [2:0] rl;
  wire [31:0] rd;
  wire [3:0] ps, ks, ws;
  wire [767:0] msg;
  wire [6:0] len;
  wire [255:0] kw, kr, dg;
  wire [15:0] pol;
  wire [7:0] bud, rc;
  integer err_count = 0;
  integer checks_done = 0;
  integer nw = 0;
  integer n, i;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (st) m <= msg;
    if (we) begin
      wk <= kw;
      wsl <= ws;
      nw <= nw + 1;
    end
  end
  mvkd_cmd #(.REV_WORD(32'h0000_00A7)) mvkd_cmd_inst (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cv),
    .cmd_opcode(op), .cmd_param1(p1), .cmd_param2(p2), .din_valid(dv), .din_byte(db), .temp_digest(tmp),
    .temp_valid(tv), .nonce_origin_flag(nf), .serial_num(72'h1122_3344_5566_7788_99), .otp_low({8{8'h3C}}),
    .pol_rd_data(pol), .key_rd_data(kr), .sha_done(sd), .sha_digest(dg), .ctr_sel(sel), .busy_ff(busy),
    .rsp_valid_ff(rv), .rsp_len_ff(rl), .rsp_data_ff(rd), .pol_rd_slot_ff(ps), .key_rd_slot_ff(ks),
    .sha_start_ff(st), .sha_msg_ff(msg), .sha_len_ff(len), .key_wr_en_ff(we), .key_wr_slot_ff(ws),
    .key_wr_data_ff(kw), .ctr_budget_ff(bud), .ctr_rewrite_ff(rc));
  mvkd_store mvkd_store_inst (.core_clk(core_clk), .pol_slot(ps), .key_slot(ks), .sha_start(st),
    .sha_len(len), .pol_data(pol), .key_data(kr), .sha_done(sd), .sha_digest(dg));
  task chk(input [47:0] nm, input [767:0] s, input [767:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s exp %0h seen %0h", nm, e, s);
      end
    end
  endtask
  task cmd(input [7:0] o, input [7:0] a, input [15:0] b);
    begin
      @(posedge core_clk);
      op <= o;
      p1 <= a;
      p2 <= b;
      cv <= 1;
      @(posedge core_clk);
      cv <= 0;
    end
  endtask
  task data(input [7:0] b, input integer c);
    integer j;
    for (j = 0; j < c; j = j + 1) begin
      @(posedge core_clk);
      dv <= 1;
      db <= b;
    end
  endtask
  // extra fields sent first byte first, as the client's own mac message
  task xtra(input [103:0] x);
    integer j;
    for (j = 12; j >= 0; j = j - 1) begin
      @(posedge core_clk);
      dv <= 1;
      db <= x[8*j +: 8];
    end
  endtask
  // bounded wait; next command only once busy has dropped
  task rsp;
    begin
      if (dv) @(posedge core_clk) dv <= 0;
      n = 0;
      while (rv !== 1'b1 && n < 300) begin
        @(negedge core_clk);
        n = n + 1;
      end
      v = rd;
      if (n == 300) err_count = err_count + 1;
      repeat (2) @(negedge core_clk);
    end
  endtask
  task ku(input [15:0] s, input [7:0] a, input [7:0] mb, input [7:0] e);
    begin
      cmd(`MVKD_OP_KEYUPD, a, s);
      if (mb != 8'h00) begin
        repeat (2) @(posedge core_clk);
        data(mb, 32);
      end
      rsp;
      chk("kures", v[7:0], e);
    end
  endtask
  task t_rev;
    begin
      chk("rst", {busy, rv, bud, rc}, 18'h0FF00);
      cmd(`MVKD_OP_REV, 8'h00, 16'h0000);
      rsp;
      chk("revval", {rl, v}, {3'h4, 32'h0000_00A7});
      cmd(`MVKD_OP_REV, 8'h01, 16'h0000);
      rsp;
      chk("revbad", v[7:0], `MVKD_ERR_PARSE);
      $display("t_rev done");
    end
  endtask
  task t_ver;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        cmd(`MVKD_OP_VERIFY, {2'b00, i[2], 3'b000, i[1:0]}, 16'hFFF5);
        repeat (2) @(posedge core_clk);
        data(8'hC1, 32);
        data(i == 3 ? 8'h59 : 8'h58, 32);
        xtra(104'h08_00_05_00_3D3D3D_55667788_3344);
        rsp;
        chk("vres", v[7:0], i == 3);
        chk("vkey", m[767:512], i[1] ? tmp : {32{8'hA5}});
        chk("vchal", m[511:256], i[0] ? tmp : {32{8'hC1}});
        chk("vtail", m[255:0], {32'h08000500, i[2] ? {8{8'h3C}} : 64'h0, 32'h3D3D3D99, 64'h5566778811223344, 64'h0});
      end
      $display("t_ver done");
    end
  endtask
  task t_key;
    begin
      ku(16'h0002, 8'h00, 8'h00, `MVKD_RES_OK);
      chk("kuwr", {wsl, wk}, {4'h2, {32{8'h60}}});
      chk("kumsg", m, {{32{8'hA2}}, 56'h1C000002991122, 200'h0, tmp});
      chk("kucnt", {bud, rc}, 16'hFF01);
      ku(16'h0003, 8'h00, 8'h00, `MVKD_ERR_EXEC);
      ku(16'h0002, 8'h04, 8'h00, `MVKD_ERR_PARSE);
      @(posedge core_clk) tv <= 1'b0;
      ku(16'h0002, 8'h00, 8'h00, `MVKD_ERR_PARSE);
      @(posedge core_clk);
      tv <= 1'b1;
      nf <= 1'b1;
      ku(16'h0002, 8'h00, 8'h00, `MVKD_ERR_PARSE);
      @(posedge core_clk) nf <= 1'b0;
      chk("kuno", {rc, nw[7:0]}, 16'h0101);
      @(posedge core_clk) sel <= 3'h4;
      ku(16'h0004, 8'h00, 8'h27, `MVKD_RES_OK);
      chk("kumac", {wsl, m[767:512]}, {4'h4, {32{8'hA2}}});
      ku(16'h0004, 8'h00, 8'h26, `MVKD_ERR_EXEC);
      chk("kuno2", {rc, nw[7:0]}, 16'h0102);
      $display("t_key done");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1;
    t_rev;
    t_ver;
    t_key;
    end_of_test;
  end
  // whole run is well under a thousand cycles
  initial begin
    #400000;
    err_count = err_count + 1;
    end_of_test;
  end
endmodule // tb
bind mvkd_cmd mvkd_chk mvkd_chk_inst (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode), .cmd_param1(cmd_param1), .cmd_param2(cmd_param2), .sha_done(sha_done),
  .busy_ff(busy_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_len_ff(rsp_len_ff), .rsp_data_ff(rsp_data_ff),
  .pol_rd_slot_ff(pol_rd_slot_ff), .sha_start_ff(sha_start_ff), .sha_len_ff(sha_len_ff),
  .key_wr_en_ff(key_wr_en_ff));
